/* File: ccr_ctrl_regs.sv */
// can control, status and fifo pointer registers on apb
`timescale 1ns/1ps
`default_nettype none
`include "ccr_params.svh"
module ccr_ctrl_regs
    import ccr_pkg::*;
#(
    parameter int IDLE_BITS = `CCR_IDLE_BITS
) (
    input wire logic I_CLK_SYS, // 40 mhz clock
    input wire logic I_RST, // async reset, high
    input wire logic I_CE, // clock enable
    input wire logic I_PSEL, // apb select
    input wire logic I_PENABLE, // apb access phase
    input wire logic I_PWRITE, // apb write
    input wire logic [7:0] I_PADDR, // apb byte address
    input wire logic [31:0] I_PWDATA, // apb write data
    output logic O_PREADY, // apb ready
    output logic [31:0] O_PRDATA, // apb read data
    output logic O_PSLVERR, // apb error, unmapped
    input wire logic I_BIT_TICK, // bus bit strobe
    input wire logic I_RX_LEVEL, // bus level, 1 recessive
    input wire logic I_TX_BUSY, // transmission running
    input wire logic I_TX_ALL_ABORTED, // all buffers aborted
    input wire logic I_DEV_IDLE, // device in idle mode
    input wire logic I_RX_MSG_DONE, // message received pulse
    input wire logic [3:0] I_FILTER_HIT, // matching filter
    input wire logic [4:0] I_DATA_FILTER_DEPTH, // depth
    input wire logic [3:0] I_PEND_MOD, // fifo,ovf,wake,err
    input wire logic [15:0] I_PEND_BUF, // buffer pending
    input wire logic I_FIFO_WR_ADV, // fifo buffer filled
    input wire logic I_FIFO_RD_ADV, // fifo buffer read
    output logic [2:0] O_MODE_REPORT, // mode in force
    output logic O_ABORT_ALL_TX, // abort all pending tx
    output logic O_HALT, // stopped in idle
    output logic O_CAPTURE_EVENT, // capture pulse
    output logic O_WINDOW_SELECT, // 1 filter window
    output logic O_DEPTH_VALID, // depth code usable
    output logic [5:0] O_DMA_BUFFER_COUNT, // buffers
    output logic [5:0] O_FIFO_BUFFER_POINTER, // write ptr
    output logic [5:0] O_FIFO_NEXT_READ_POINTER // read ptr
);

    // ------------------------------------------------------
    // helper functions
    // ------------------------------------------------------

    // buffers held in dma memory; reserved code gives 32
    function automatic logic [5:0] buf_count(
        input logic [2:0] bs
    );
        case (bs)
            3'h0: buf_count = 6'h04;
            3'h1: buf_count = 6'h06;
            3'h2: buf_count = 6'h08;
            3'h3: buf_count = 6'h0c;
            3'h4: buf_count = 6'h10;
            3'h5: buf_count = 6'h18;
            default: buf_count = 6'h20;
        endcase
    endfunction

    // step a fifo pointer, wrapping from the last buffer
    // back to the start; a start beyond the last buffer
    // pins the pointer there, software misconfigured it
    function automatic logic [5:0] next_ptr(
        input logic [5:0] ptr,
        input logic [4:0] start,
        input logic [2:0] bs
    );
        logic [5:0] last;
        last = buf_count(bs) - 6'h01;
        if (ptr >= last) begin
            next_ptr = {1'b0, start};
        end else begin
            next_ptr = ptr + 6'h01;
        end
    endfunction

    // pick one pending source: module events first,
    // then the lowest numbered buffer
    function automatic logic [6:0] pick_code(
        input logic [3:0] pm,
        input logic [15:0] pb
    );
        pick_code = `CCR_INTERRUPT_CODE_NONE;
        for (int i = 15; i >= 0; i--) begin
            if (pb[i]) begin
                pick_code = 7'(i);
            end
        end
        if (pm[3]) begin
            pick_code = `CCR_INTERRUPT_CODE_FIFO;
        end
        if (pm[2]) begin
            pick_code = `CCR_INTERRUPT_CODE_OVF;
        end
        if (pm[1]) begin
            pick_code = `CCR_INTERRUPT_CODE_WAKE;
        end
        if (pm[0]) begin
            pick_code = `CCR_INTERRUPT_CODE_ERR;
        end
    endfunction

    // reserved mode codes are never taken into force
    function automatic logic mode_ok(input ccr_mode_t m);
        mode_ok = (m != `CCR_MODE_RSV0) &&
                  (m != `CCR_MODE_RSV1);
    endfunction

    // ------------------------------------------------------
    // state and bus idle detector
    // ------------------------------------------------------

    ccr_state_s st_ff;
    ccr_state_s nxt_st;
    logic bus_idle;

    ccr_bus_idle #(
        .IDLE_BITS(IDLE_BITS)
    ) u_idle (
        .i_clk(I_CLK_SYS),
        .i_rst(I_RST),
        .i_ce(I_CE),
        .i_bit_tick(I_BIT_TICK),
        .i_rx_level(I_RX_LEVEL),
        .o_bus_idle(bus_idle)
    );

    // ------------------------------------------------------
    // apb decode
    // ------------------------------------------------------

    logic setup;
    logic wr_acc;
    logic mapped;
    logic in_cfg;
    logic [31:0] wd;

    // access completes in one cycle, so the write lands on
    // the edge that ends the access phase
    always_comb begin
        setup = I_PSEL && !I_PENABLE;
        wr_acc = I_PSEL && I_PENABLE && I_PWRITE;
        wd = I_PWDATA;
        in_cfg = (st_ff.mode_rep == `CCR_MODE_CONFIG);
        case (I_PADDR)
            `CCR_OFS_MAIN_CTRL,
            `CCR_OFS_FILT_DEPTH,
            `CCR_OFS_INT_CODE,
            `CCR_OFS_FIFO_CTRL,
            `CCR_OFS_FIFO_STAT: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // ------------------------------------------------------
    // next state
    // ------------------------------------------------------

    always_comb begin
        nxt_st = st_ff;

        // read data and error are fixed in the setup cycle
        // and held through the access phase
        if (setup) begin
            nxt_st.slverr = !mapped;
            case (I_PADDR)
                `CCR_OFS_MAIN_CTRL: begin
                    nxt_st.rdata = {18'h0,
                        st_ff.stop_idle, st_ff.abort,
                        1'b0, st_ff.mode_req,
                        st_ff.mode_rep, 1'b0,
                        st_ff.cap_en, 2'h0,
                        st_ff.window_select};
                end
                `CCR_OFS_FILT_DEPTH: begin
                    nxt_st.rdata = {27'h0, st_ff.depth};
                end
                `CCR_OFS_INT_CODE: begin
                    nxt_st.rdata = {19'h0, 1'b0, st_ff.hit,
                        1'b0, st_ff.interrupt_code};
                end
                `CCR_OFS_FIFO_CTRL: begin
                    nxt_st.rdata = {16'h0, st_ff.dma_bs,
                        8'h0, st_ff.fstart};
                end
                `CCR_OFS_FIFO_STAT: begin
                    nxt_st.rdata = {18'h0, st_ff.fifo_buffer_pointer,
                        2'h0, st_ff.fifo_next_read_pointer};
                end
                default: begin
                    nxt_st.rdata = 32'h0;
                end
            endcase
        end

        // abort self-clears once the engine confirms; a new
        // write of one in the same cycle wins over the clear
        if (st_ff.abort && I_TX_ALL_ABORTED) begin
            nxt_st.abort = 1'b0;
        end

        // control writes; outside configuration only the
        // mode request, abort and window stay writable
        if (wr_acc && I_PADDR == `CCR_OFS_MAIN_CTRL) begin
            nxt_st.mode_req = wd[10:8];
            nxt_st.window_select = wd[`CCR_BIT_WIN];
            if (wd[`CCR_BIT_ABORT]) begin
                nxt_st.abort = 1'b1;
            end
            if (in_cfg) begin
                nxt_st.stop_idle =
                    wd[`CCR_BIT_STOP_IDLE];
                nxt_st.cap_en = wd[`CCR_BIT_CAP_EN];
            end
        end

        // fifo layout change restarts both pointers
        if (wr_acc && in_cfg &&
            I_PADDR == `CCR_OFS_FIFO_CTRL) begin
            nxt_st.dma_bs = wd[15:13];
            nxt_st.fstart = wd[4:0];
            nxt_st.fifo_buffer_pointer = {1'b0, wd[4:0]};
            nxt_st.fifo_next_read_pointer = {1'b0, wd[4:0]};
        end else begin
            if (I_FIFO_WR_ADV) begin
                nxt_st.fifo_buffer_pointer = next_ptr(st_ff.fifo_buffer_pointer,
                    st_ff.fstart, st_ff.dma_bs);
            end
            if (I_FIFO_RD_ADV) begin
                nxt_st.fifo_next_read_pointer = next_ptr(st_ff.fifo_next_read_pointer,
                    st_ff.fstart, st_ff.dma_bs);
            end
        end

        // mode change waits for an idle bus; off-bus modes
        // may leave at once, and configuration is never
        // entered while a frame is being sent
        if (st_ff.mode_req != st_ff.mode_rep &&
            mode_ok(st_ff.mode_req) &&
            (bus_idle || in_cfg ||
             st_ff.mode_rep == `CCR_MODE_DISABLE) &&
            !(st_ff.mode_req == `CCR_MODE_CONFIG &&
              I_TX_BUSY)) begin
            nxt_st.mode_rep = st_ff.mode_req;
        end

        // engine reported status
        nxt_st.depth = I_DATA_FILTER_DEPTH;
        if (I_RX_MSG_DONE) begin
            nxt_st.hit = I_FILTER_HIT;
        end
        nxt_st.interrupt_code = pick_code(I_PEND_MOD,
            I_PEND_BUF);

        // device idle and capture outputs
        nxt_st.halt = st_ff.stop_idle && I_DEV_IDLE;
        nxt_st.cap_pulse =
            st_ff.cap_en && I_RX_MSG_DONE;
    end

    // ------------------------------------------------------
    // state register
    // ------------------------------------------------------

    // reset puts the controller in configuration mode
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            st_ff <= '0;
            st_ff.mode_req <= `CCR_MODE_CONFIG;
            st_ff.mode_rep <= `CCR_MODE_CONFIG;
            st_ff.interrupt_code <= `CCR_INTERRUPT_CODE_NONE;
        end else if (I_CE) begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------
    // outputs
    // ------------------------------------------------------

    // ready follows the enable so a frozen block stalls
    assign O_PREADY = I_CE;
    assign O_PRDATA = st_ff.rdata;
    assign O_PSLVERR = I_PSEL && I_PENABLE && st_ff.slverr;
    assign O_MODE_REPORT = st_ff.mode_rep;
    assign O_ABORT_ALL_TX = st_ff.abort;
    assign O_HALT = st_ff.halt;
    assign O_CAPTURE_EVENT = st_ff.cap_pulse;
    assign O_WINDOW_SELECT = st_ff.window_select;
    assign O_DEPTH_VALID =
        (st_ff.depth <= `CCR_DEPTH_MAX);
    assign O_DMA_BUFFER_COUNT = buf_count(st_ff.dma_bs);
    assign O_FIFO_BUFFER_POINTER = st_ff.fifo_buffer_pointer;
    assign O_FIFO_NEXT_READ_POINTER = st_ff.fifo_next_read_pointer;

endmodule
`default_nettype wire

/* File: ccr_params.svh */
// constants of the can control and status register set
//
// Overview of operation
// - three-bit mode request selects operating mode
// - read-only mode report shows mode in force
// - request and report reset to configuration
// - abort-all bit set by software, self-clears
// - stop-in-idle halts controller in device idle
// - capture enable gives event per received message
// - window select picks filter or buffer map
// - five-bit data filter depth, high codes invalid
// - read-only filter hit number zero to fifteen
// - interrupt code resets to no interrupt
// - module events use codes 65 to 68
// - buffer events use buffer number as code
// - dma buffer count field, code 111 reserved
// - writable fifo start buffer field
// - read-only fifo buffer pointer
// - read-only next read buffer pointer
// - mode changes after bus idle, at once from configuration or disable
// - outside configuration, stop-in-idle, capture and fifo writes are locked
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH

// ----------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------
`define CCR_OFS_MAIN_CTRL 8'h00
`define CCR_OFS_FILT_DEPTH 8'h04
`define CCR_OFS_INT_CODE 8'h08
`define CCR_OFS_FIFO_CTRL 8'h0c
`define CCR_OFS_FIFO_STAT 8'h10

// ----------------------------------------------------------
// field positions
// ----------------------------------------------------------
`define CCR_BIT_STOP_IDLE 13
`define CCR_BIT_ABORT 12
`define CCR_BIT_CAP_EN 3
`define CCR_BIT_WIN 0

// ----------------------------------------------------------
// encodings and reset values
// ----------------------------------------------------------
`define CCR_MODE_NORMAL 3'h0
`define CCR_MODE_DISABLE 3'h1
`define CCR_MODE_LOOPBACK 3'h2
`define CCR_MODE_LISTEN 3'h3
`define CCR_MODE_CONFIG 3'h4
`define CCR_MODE_RSV0 3'h5
`define CCR_MODE_RSV1 3'h6
`define CCR_MODE_LISTEN_ALL 3'h7
`define CCR_DEPTH_MAX 5'h11
`define CCR_INTERRUPT_CODE_NONE 7'h40
`define CCR_INTERRUPT_CODE_ERR 7'h41
`define CCR_INTERRUPT_CODE_WAKE 7'h42
`define CCR_INTERRUPT_CODE_OVF 7'h43
`define CCR_INTERRUPT_CODE_FIFO 7'h44
`define CCR_IDLE_BITS 11

`endif

/* File: ccr_pkg.sv */
// types of the can control and status register set
package ccr_pkg;

    typedef logic [2:0] ccr_mode_t;

    // whole state of the register set
    typedef struct packed {
        logic stop_idle;
        logic abort;
        ccr_mode_t mode_req;
        ccr_mode_t mode_rep;
        logic cap_en;
        logic window_select;
        logic [4:0] depth;
        logic [3:0] hit;
        logic [6:0] interrupt_code;
        logic [2:0] dma_bs;
        logic [4:0] fstart;
        logic [5:0] fifo_buffer_pointer;
        logic [5:0] fifo_next_read_pointer;
        logic [31:0] rdata;
        logic slverr;
        logic halt;
        logic cap_pulse;
    } ccr_state_s;

    // state of the bus idle detector
    typedef struct packed {
        logic [3:0] cnt;
        logic idle;
    } ccr_idle_s;

endpackage

/* File: ccr_bus_idle.sv */
// bus idle detector: counts consecutive recessive bits
`timescale 1ns/1ps
`default_nettype none
`include "ccr_params.svh"
module ccr_bus_idle
    import ccr_pkg::*;
#(
    parameter int IDLE_BITS = `CCR_IDLE_BITS
) (
    input wire logic i_clk, // system clock
    input wire logic i_rst, // async reset, high
    input wire logic i_ce, // clock enable
    input wire logic i_bit_tick, // one pulse per bus bit
    input wire logic i_rx_level, // sampled bus level, 1 recessive
    output logic o_bus_idle // enough recessive bits seen
);

    ccr_idle_s st_ff;
    ccr_idle_s nxt_st;

    // saturating count, any dominant bit restarts it
    always_comb begin
        nxt_st = st_ff;
        if (i_bit_tick) begin
            if (!i_rx_level) begin
                nxt_st.cnt = 4'h0;
            end else if (st_ff.cnt != IDLE_BITS[3:0]) begin
                nxt_st.cnt = st_ff.cnt + 4'h1;
            end
        end
        nxt_st.idle = (nxt_st.cnt == IDLE_BITS[3:0]);
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_ff <= '0;
        end else if (i_ce) begin
            st_ff <= nxt_st;
        end
    end

    assign o_bus_idle = st_ff.idle;

endmodule
`default_nettype wire

/* File: ccr_ctrl_regs_properties.sv */
// port assertions for the can control register set
`timescale 1ns/1ps
`default_nettype none
`include "ccr_params.svh"
module ccr_ctrl_regs_properties
    import ccr_pkg::*;
#(
    parameter int IDLE_BITS = `CCR_IDLE_BITS
) (
    input wire logic I_CLK_SYS, // clock
    input wire logic I_RST, // async reset
    input wire logic I_CE, // clock enable
    input wire logic I_PSEL, // apb select
    input wire logic I_PENABLE, // apb access
    input wire logic I_PWRITE, // apb write
    input wire logic [7:0] I_PADDR, // apb address
    input wire logic [31:0] I_PWDATA, // apb write data
    input wire logic I_TX_ALL_ABORTED, // aborts done
    input wire logic I_DEV_IDLE, // device idle
    input wire logic I_RX_MSG_DONE, // message received
    input wire logic [4:0] I_DATA_FILTER_DEPTH, // depth
    input wire logic I_FIFO_RD_ADV, // read step
    input wire logic [2:0] O_MODE_REPORT, // mode in force
    input wire logic O_ABORT_ALL_TX, // abort request
    input wire logic O_HALT, // halted
    input wire logic O_CAPTURE_EVENT, // capture pulse
    input wire logic O_DEPTH_VALID, // depth usable
    input wire logic [5:0] O_DMA_BUFFER_COUNT, // buffers
    input wire logic [5:0] O_FIFO_BUFFER_POINTER, // write ptr
    input wire logic [5:0] O_FIFO_NEXT_READ_POINTER // read ptr
);
    logic wr_ctl;
    logic wr_fifo;
    // -----------------------------------------
    // write strobes seen at the access edge
    // -----------------------------------------
    assign wr_ctl = I_PSEL & I_PENABLE & I_PWRITE & I_CE
        & (I_PADDR == `CCR_OFS_MAIN_CTRL);
    assign wr_fifo = I_PSEL & I_PENABLE & I_PWRITE & I_CE
        & (I_PADDR == `CCR_OFS_FIFO_CTRL);
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RST);
    a_mode_not_reserved: assert property (
        O_MODE_REPORT != `CCR_MODE_RSV0 && O_MODE_REPORT != `CCR_MODE_RSV1)
        else $error("mode report shows reserved code");
    a_mode_reset_config: assert property (disable iff (1'b0)
        I_RST |-> O_MODE_REPORT == `CCR_MODE_CONFIG)
        else $error("mode report not config in reset");
    a_abort_set: assert property (
        wr_ctl && I_PWDATA[`CCR_BIT_ABORT] |=> O_ABORT_ALL_TX)
        else $error("abort write did not set");
    a_abort_self_clear: assert property (
        O_ABORT_ALL_TX && I_TX_ALL_ABORTED
        && !(wr_ctl && I_PWDATA[`CCR_BIT_ABORT]) |=> !O_ABORT_ALL_TX)
        else $error("abort not cleared");
    a_halt_needs_idle: assert property (
        O_HALT |-> $past(I_DEV_IDLE))
        else $error("halt without device idle");
    a_capture_cause: assert property (
        O_CAPTURE_EVENT |-> $past(I_RX_MSG_DONE))
        else $error("capture event without message");
    a_depth_valid: assert property (
        O_DEPTH_VALID == ($past(I_DATA_FILTER_DEPTH) <= `CCR_DEPTH_MAX))
        else $error("depth valid flag wrong");
    a_dma_count_legal: assert property (
        O_DMA_BUFFER_COUNT inside {6'h04, 6'h06, 6'h08, 6'h0c, 6'h10,
        6'h18, 6'h20})
        else $error("dma buffer count not a legal size");
    a_ptr_in_range: assert property (
        O_FIFO_BUFFER_POINTER <= 6'h1f && O_FIFO_NEXT_READ_POINTER <= 6'h1f)
        else $error("fifo pointer beyond buffer 31");
    a_read_ptr_hold: assert property (
        !$past(I_FIFO_RD_ADV) && !$past(wr_fifo)
        |-> $stable(O_FIFO_NEXT_READ_POINTER))
        else $error("read pointer moved without a step");
endmodule
bind ccr_ctrl_regs ccr_ctrl_regs_properties #(.IDLE_BITS(IDLE_BITS)) u_prop (
    .I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_CE(I_CE), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
    .I_PWDATA(I_PWDATA), .I_TX_ALL_ABORTED(I_TX_ALL_ABORTED),
    .I_DEV_IDLE(I_DEV_IDLE), .I_RX_MSG_DONE(I_RX_MSG_DONE),
    .I_DATA_FILTER_DEPTH(I_DATA_FILTER_DEPTH), .I_FIFO_RD_ADV(I_FIFO_RD_ADV),
    .O_MODE_REPORT(O_MODE_REPORT), .O_ABORT_ALL_TX(O_ABORT_ALL_TX),
    .O_HALT(O_HALT), .O_CAPTURE_EVENT(O_CAPTURE_EVENT),
    .O_DEPTH_VALID(O_DEPTH_VALID), .O_DMA_BUFFER_COUNT(O_DMA_BUFFER_COUNT),
    .O_FIFO_BUFFER_POINTER(O_FIFO_BUFFER_POINTER),
    .O_FIFO_NEXT_READ_POINTER(O_FIFO_NEXT_READ_POINTER));
`default_nettype wire

/* File: ccr_bus_node.sv */
// far side model: bus bit stream and transmit buffer abort response
`timescale 1ns/1ps
`default_nettype none
module ccr_bus_node (
    input wire logic i_clk, // system clock
    input wire logic i_rst, // async reset, high
    input wire logic i_busy_bus, // 1 other nodes keep bus active
    input wire logic i_abort_req, // abort request from controller
    output logic o_bit_tick, // one pulse per bus bit
    output logic o_rx_level, // bus level, 1 recessive
    output logic o_all_aborted // every buffer has given up
);
    logic [1:0] div_ff;
    logic [1:0] ab_ff;
    // a busy bus toggles each bit so no idle run can build up
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            div_ff <= 2'h0;
            ab_ff <= 2'h0;
            o_bit_tick <= 1'b0;
            o_rx_level <= 1'b1;
            o_all_aborted <= 1'b0;
        end else begin
            div_ff <= div_ff + 2'h1;
            o_bit_tick <= (div_ff == 2'h3);
            if (div_ff == 2'h3) begin
                o_rx_level <= i_busy_bus ? ~o_rx_level : 1'b1;
            end
            // buffers need a few cycles to abandon their frames
            ab_ff <= !i_abort_req ? 2'h0 : (ab_ff == 2'h3) ? ab_ff : ab_ff + 2'h1;
            o_all_aborted <= (ab_ff == 2'h2);
        end
    end
endmodule
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the can control register set
`timescale 1ns/1ps
`default_nettype none
`include "ccr_params.svh"
module testbench import ccr_pkg::*;;
    logic clk = 0, rst = 0, psel = 0, pen = 0, pwr = 0, busy_bus = 1;
    logic dev_idle = 0, rx_done = 0, wr_adv = 0, rd_adv = 0, err;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    logic [3:0] hit = 0, pmod = 0;
    logic [15:0] pbuf = 0;
    logic [4:0] depth = 0;
    wire logic pready, pslverr, tick, rxl, all_ab, abort, halt, cap, window_select, dval;
    wire logic [31:0] prdata;
    wire logic [2:0] mode;
    wire logic [5:0] dmac, fifo_buffer_pointer, fifo_next_read_pointer;
    int n_errors = 0, n_compared = 0;
    logic [5:0] sizes [8] = '{6'h04, 6'h06, 6'h08, 6'h0c, 6'h10, 6'h18,
        6'h20, 6'h20};
    always #12.5 clk = ~clk;
    ccr_ctrl_regs DUT (.I_CLK_SYS(clk), .I_RST(rst), .I_CE(1'b1),
        .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
        .I_PWDATA(pwdata), .O_PREADY(pready), .O_PRDATA(prdata),
        .O_PSLVERR(pslverr), .I_BIT_TICK(tick), .I_RX_LEVEL(rxl),
        .I_TX_BUSY(1'b0), .I_TX_ALL_ABORTED(all_ab), .I_DEV_IDLE(dev_idle),
        .I_RX_MSG_DONE(rx_done), .I_FILTER_HIT(hit),
        .I_DATA_FILTER_DEPTH(depth), .I_PEND_MOD(pmod), .I_PEND_BUF(pbuf),
        .I_FIFO_WR_ADV(wr_adv), .I_FIFO_RD_ADV(rd_adv),
        .O_MODE_REPORT(mode), .O_ABORT_ALL_TX(abort), .O_HALT(halt),
        .O_CAPTURE_EVENT(cap), .O_WINDOW_SELECT(window_select),
        .O_DEPTH_VALID(dval), .O_DMA_BUFFER_COUNT(dmac),
        .O_FIFO_BUFFER_POINTER(fifo_buffer_pointer), .O_FIFO_NEXT_READ_POINTER(fifo_next_read_pointer));
    ccr_bus_node u_node (.i_clk(clk), .i_rst(rst), .i_busy_bus(busy_bus),
        .i_abort_req(abort), .o_bit_tick(tick), .o_rx_level(rxl),
        .o_all_aborted(all_ab));
    // ------------------------------------------
    // shared tasks
    // ------------------------------------------
    task conclude;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // apb transfer, request held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1;
        k = 0;
        do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 16);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        pen <= 0;
        if (k >= 16) begin n_errors++; conclude(); end
        #1;
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(0, a, 0);
        chk(rd, e);
    endtask
    // bounded wait for the mode report to reach a code
    task wait_mode(input logic [2:0] m);
        int k;
        for (k = 0; mode !== m && k < 200; k++) @(posedge clk);
        chk(mode, m);
        if (k >= 200) conclude();
    endtask
    // one-cycle pulse: 0 message done, 1 write step, 2 read step
    task step(input int w);
        @(posedge clk);
        case (w)
            0: rx_done <= 1;
            1: wr_adv <= 1;
            default: rd_adv <= 1;
        endcase
        @(posedge clk);
        rx_done <= 0;
        wr_adv <= 0;
        rd_adv <= 0;
        #1;
    endtask
    // ------------------------------------------
    // scenarios
    // ------------------------------------------
    task t_reset;
        rdchk(`CCR_OFS_MAIN_CTRL, 32'h0480);
        rdchk(`CCR_OFS_INT_CODE, 32'h0040);
        rdchk(`CCR_OFS_FIFO_STAT, 32'h0);
        apb(1, `CCR_OFS_INT_CODE, 32'hffff);
        rdchk(`CCR_OFS_INT_CODE, 32'h0040);
        apb(1, 8'h14, 32'hffff);
        chk(err, 1);
        rdchk(8'h14, 32'h0);
        $display("reset test done");
    endtask
    task t_ctrl;
        apb(1, `CCR_OFS_MAIN_CTRL, 32'hffff_f409);
        rdchk(`CCR_OFS_MAIN_CTRL, 32'h3489);
        chk(window_select, 1);
        hit <= 4'hb;
        step(0);
        chk(cap, 1);
        dev_idle <= 1;
        repeat (2) @(posedge clk);
        #1 chk(halt, 1);
        dev_idle <= 0;
        depth <= 5'h12;
        repeat (2) @(posedge clk);
        #1 chk(dval, 0);
        rdchk(`CCR_OFS_FILT_DEPTH, 32'h12);
        depth <= 5'h11;
        repeat (2) @(posedge clk);
        #1 chk(dval, 1);
        $display("control test done");
    endtask
    task t_interrupt_code;
        for (int i = 0; i < 4; i++) begin
            pmod <= 4'h1 << i;
            pbuf <= 16'h0200;
            rdchk(`CCR_OFS_INT_CODE, 32'h0b41 + i);
        end
        pmod <= 4'h6;
        rdchk(`CCR_OFS_INT_CODE, 32'h0b42);
        pmod <= 0;
        rdchk(`CCR_OFS_INT_CODE, 32'h0b09);
        pbuf <= 16'h8000;
        rdchk(`CCR_OFS_INT_CODE, 32'h0b0f);
        pbuf <= 0;
        rdchk(`CCR_OFS_INT_CODE, 32'h0b40);
        $display("interrupt code test done");
    endtask
    task t_fifo;
        for (int c = 0; c < 8; c++) begin
            apb(1, `CCR_OFS_FIFO_CTRL, {16'h0, c[2:0], 13'h0});
            chk(dmac, sizes[c]);
        end
        apb(1, `CCR_OFS_FIFO_CTRL, 32'h2002);
        rdchk(`CCR_OFS_FIFO_CTRL, 32'h2002);
        rdchk(`CCR_OFS_FIFO_STAT, 32'h0202);
        repeat (4) step(1);
        chk(fifo_buffer_pointer, 6'h02);
        step(2);
        rdchk(`CCR_OFS_FIFO_STAT, 32'h0203);
        $display("fifo test done");
    endtask
    task t_mode;
        apb(1, `CCR_OFS_MAIN_CTRL, 32'h2009);
        wait_mode(`CCR_MODE_NORMAL);
        apb(1, `CCR_OFS_MAIN_CTRL, 32'h0);
        rdchk(`CCR_OFS_MAIN_CTRL, 32'h2008);
        apb(1, `CCR_OFS_MAIN_CTRL, 32'h0200);
        repeat (80) @(posedge clk);
        chk(mode, `CCR_MODE_NORMAL);
        busy_bus <= 0;
        wait_mode(`CCR_MODE_LOOPBACK);
        apb(1, `CCR_OFS_MAIN_CTRL, 32'h0500);
        repeat (60) @(posedge clk);
        chk(mode, `CCR_MODE_LOOPBACK);
        foreach (sizes[i]) if (i < 5) begin
            apb(1, `CCR_OFS_MAIN_CTRL, {21'h0, 3'(32'h0304_7300 >> (i*6)), 8'h0});
            wait_mode(3'(32'h0304_7300 >> (i*6)));
        end
        $display("mode test done");
    endtask
    task t_abort;
        int k;
        apb(1, `CCR_OFS_MAIN_CTRL, 32'h1400);
        chk(abort, 1);
        for (k = 0; abort === 1'b1 && k < 20; k++) @(posedge clk);
        #1 chk(abort, 0);
        rdchk(`CCR_OFS_MAIN_CTRL, 32'h0480);
        $display("abort test done");
    endtask
    initial begin
        rst = 1;
        repeat (3) @(posedge clk);
        rst <= 0;
        t_reset();
        t_ctrl();
        t_interrupt_code();
        t_fifo();
        t_mode();
        t_abort();
        conclude();
    end
endmodule
`default_nettype wire
